// ===== rtl/odcd_pkg.sv
// Package: constants, types and state layout for the OLED command decoder
package odcd_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_GEOM = 8'h0C;
  localparam logic [7:0] OFS_TIMING = 8'h10;
  localparam logic [7:0] OFS_DIM = 8'h14;
  localparam logic [7:0] OFS_SCROLL = 8'h18;
  localparam logic [7:0] OFS_VAREA = 8'h1C;
  localparam logic [7:0] OFS_BANKCOL = 8'h20;
  localparam logic [7:0] OFS_DATACNT = 8'h24;

  // ----------------------------------------------------------------
  // Field positions and bus answers
  // ----------------------------------------------------------------
  localparam int CMD_DC_BIT = 8;
  localparam int STATUS_OFF_BIT = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LOWCOL = 8'h00;
  localparam logic [7:0] OP_ADDRMODE = 8'h20;
  localparam logic [7:0] OP_COLADDR = 8'h21;
  localparam logic [7:0] OP_PAGEADDR = 8'h22;
  localparam logic [7:0] OP_HSCR_R = 8'h26;
  localparam logic [7:0] OP_HSCR_L = 8'h27;
  localparam logic [7:0] OP_SCR_R = 8'h29;
  localparam logic [7:0] OP_SCR_L = 8'h2A;
  localparam logic [7:0] OP_SCR_OFF = 8'h2E;
  localparam logic [7:0] OP_SCR_ON = 8'h2F;
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [7:0] OP_BRIGHT = 8'h82;
  localparam logic [7:0] OP_LUT = 8'h91;
  localparam logic [7:0] OP_BANK_LO = 8'h92;
  localparam logic [7:0] OP_BANK_HI = 8'h93;
  localparam logic [7:0] OP_SEG = 8'hA0;
  localparam logic [7:0] OP_VAREA = 8'hA3;
  localparam logic [7:0] OP_ENTIRE = 8'hA4;
  localparam logic [7:0] OP_INV = 8'hA6;
  localparam logic [7:0] OP_MUX = 8'hA8;
  localparam logic [7:0] OP_DIM = 8'hAB;
  localparam logic [7:0] OP_DON_DIM = 8'hAC;
  localparam logic [7:0] OP_MCFG = 8'hAD;
  localparam logic [7:0] OP_DOFF = 8'hAE;
  localparam logic [7:0] OP_DON = 8'hAF;
  localparam logic [7:0] OP_PAGE = 8'hB0;
  localparam logic [7:0] OP_SCAN = 8'hC0;
  localparam logic [7:0] OP_OFFSET = 8'hD3;
  localparam logic [7:0] OP_CLK = 8'hD5;
  localparam logic [7:0] OP_AREA = 8'hD8;
  localparam logic [7:0] OP_PRE = 8'hD9;
  localparam logic [7:0] OP_PINS = 8'hDA;
  localparam logic [7:0] OP_DESEL = 8'hDB;
  localparam logic [7:0] OP_RMW_IN = 8'hE0;
  localparam logic [7:0] OP_RMW_OUT = 8'hEE;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] MUX_RST = 6'h3F;
  localparam logic [3:0] OSC_RST = 4'h7;
  localparam logic [3:0] PRE_RST = 4'h2;
  localparam logic [6:0] VROWS_RST = 7'h40;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ODCD_OFF = 2'b00,
    ODCD_ON = 2'b01,
    ODCD_DIM = 2'b10
  } odcd_disp_e;

  typedef struct packed {
    logic [1:0] dir;
    logic [2:0] shift;
    logic [2:0] start;
    logic [2:0] ivl;
    logic [2:0] stop;
    logic [5:0] voff;
  } odcd_scroll_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] opcode;
    logic [2:0] remain;
    logic [2:0] pidx;
    logic [31:0] bank_col;
    logic seg_remap;
    logic entire_on;
    logic inverse;
    logic [5:0] multiplex_ratio;
    logic [3:0] dim_rsv;
    logic [7:0] dim_contrast;
    logic [7:0] dim_bright;
    logic supply_int;
    odcd_disp_e disp;
    logic [2:0] page_start;
    logic scan_rev;
    logic [5:0] disp_offset;
    logic [3:0] clk_div;
    logic [3:0] osc_set;
    logic [1:0] area_col;
    logic low_pwr;
    logic [3:0] pre1;
    logic [3:0] pre2;
    logic pin_alt;
    logic lr_remap;
    logic rmw;
    odcd_scroll_s scr_set;
    odcd_scroll_s scr_act;
    logic scr_on;
    logic [5:0] fix_rows;
    logic [6:0] scr_rows;
    logic [15:0] data_cnt;
  } odcd_state_s;

  localparam odcd_state_s ODCD_RST = '{
    awready: 1'b1, wready: 1'b1, arready: 1'b1,
    multiplex_ratio: MUX_RST, osc_set: OSC_RST, pre1: PRE_RST, pre2: PRE_RST,
    pin_alt: 1'b1, scr_rows: VROWS_RST, disp: ODCD_OFF, default: '0};

endpackage

// ===== rtl/odcd_decoder.sv
// Module: OLED controller command decoder behind an AXI4-Lite slave
//
// Summary of operation
// - Command 93 plus four bytes sets 2-bit colours of banks 17..32, low first.
// - A0/A1 bit 0 picks column 0 or 131 for column driver zero.
// - A4/A5 bit 0 follows memory content or lights whole display.
// - A6/A7 bit 0 selects normal or inverse pixel polarity.
// - A8 parameter N sets multiplex ratio N+1; values 0..14 are forbidden.
// - AB takes reserved nibble, base bank dim contrast, then dim bank brightness.
// - AD parameter bit 0 picks external supply or internal converter.
// - AE sleeps the display, AF turns it on normal, AC on dim.
// - B0..B7 load low three bits as page start address.
// - C0/C8 bit 3 selects forward or reversed row scan.
// - D3 parameter sets vertical display offset 0..63, reset zero.
// - D5 low nibble is clock divide minus one, high nibble oscillator setting.
// - D8 bits 5:4 pick area colour, bits 2 and 0 low power.
// - D9 nibbles set pre-charge phases 1 and 2, reset 2, never zero; a zero nibble is stored as written.
// - DA bit 4 picks row pin layout, bit 5 left/right row remap.
// - E0 enters read-modify-write mode, EE leaves it.
// - 29/2A plus five bytes set vertical scroll with right or left shift.
// - Scroll interval code maps to 6,32,64,128,3,4,2 frames; 111b forbidden.
// - 2F starts scrolling with only the latest scroll setup.
// - A3 sets fixed top rows and scrolling rows, reset 0 and 64.
// - Status byte bit 6 is one while display is off.
// - Data/command select low marks command bytes, high marks memory data.
module odcd_decoder
  import odcd_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  odcd_state_s s_r;
  odcd_state_s s_nxt;
  logic aw_h;
  logic w_h;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic do_wr;
  logic do_rd;
  logic byte_v;
  logic [7:0] b;
  logic cmd_go;
  logic prm_go;
  logic data_go;

  function automatic logic [7:0] ivl_frames(input logic [2:0] c);
    case (c)
      3'h0: ivl_frames = 8'h06;
      3'h1: ivl_frames = 8'h20;
      3'h2: ivl_frames = 8'h40;
      3'h3: ivl_frames = 8'h80;
      3'h4: ivl_frames = 8'h03;
      3'h5: ivl_frames = 8'h04;
      3'h6: ivl_frames = 8'h02;
      default: ivl_frames = 8'h00;
    endcase
  endfunction

  function automatic logic [2:0] param_count(input logic [7:0] op);
    case (op)
      OP_ADDRMODE, OP_CONTRAST, OP_BRIGHT, OP_MUX, OP_MCFG: param_count = 3'h1;
      OP_OFFSET, OP_CLK, OP_AREA, OP_PRE, OP_PINS, OP_DESEL: param_count = 3'h1;
      OP_COLADDR, OP_PAGEADDR, OP_VAREA: param_count = 3'h2;
      OP_DIM: param_count = 3'h3;
      OP_LUT, OP_BANK_LO, OP_BANK_HI, OP_HSCR_R, OP_HSCR_L: param_count = 3'h4;
      OP_SCR_R, OP_SCR_L: param_count = 3'h5;
      default: param_count = 3'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  always_comb begin
    aw_h = s_r.aw_have | (s_axi_awvalid & s_r.awready);
    w_h = s_r.w_have | (s_axi_wvalid & s_r.wready);
    wa = s_r.aw_have ? s_r.aw_addr : s_axi_awaddr[7:0];
    wd = s_r.w_have ? s_r.w_data : s_axi_wdata;
    ws = s_r.w_have ? s_r.w_strb : s_axi_wstrb;
    do_wr = aw_h & w_h & ~s_r.bvalid;
    do_rd = s_axi_arvalid & s_r.arready;
    byte_v = do_wr & (wa == OFS_CMD) & ws[0];
    b = wd[7:0];
    data_go = byte_v & wd[CMD_DC_BIT];
    cmd_go = byte_v & ~wd[CMD_DC_BIT] & (s_r.remain == 3'h0);
    prm_go = byte_v & ~wd[CMD_DC_BIT] & (s_r.remain != 3'h0);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Write channels
    if (s_axi_awvalid & s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid & s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid & s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (do_wr) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = (wa == OFS_CMD) ? RESP_OKAY : RESP_SLVERR;
    end
    s_nxt.awready = ~s_nxt.aw_have & ~s_nxt.bvalid;
    s_nxt.wready = ~s_nxt.w_have & ~s_nxt.bvalid;
    // Read channel
    if (s_r.rvalid & s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (do_rd) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      case (s_axi_araddr[7:0])
        OFS_CMD: s_nxt.rdata = 32'h0000_0000;
        OFS_STATUS: s_nxt.rdata = {24'h00_0000, 1'b0, s_r.disp == ODCD_OFF, 6'h00};
        OFS_MODE: s_nxt.rdata = {18'h0_0000, s_r.rmw, s_r.scr_on, s_r.lr_remap,
          s_r.pin_alt, s_r.low_pwr, s_r.area_col, s_r.scan_rev, s_r.supply_int,
          s_r.inverse, s_r.entire_on, s_r.seg_remap, s_r.disp};
        OFS_GEOM: s_nxt.rdata = {8'h00, 2'b00, s_r.disp_offset, 5'h00, s_r.page_start,
          1'b0, 7'({1'b0, s_r.multiplex_ratio} + 7'h01)};
        OFS_TIMING: s_nxt.rdata = {8'h00, s_r.pre2, s_r.pre1, s_r.osc_set, s_r.clk_div,
          3'h0, 5'({1'b0, s_r.clk_div} + 5'h01)};
        OFS_DIM: s_nxt.rdata = {8'h00, s_r.dim_bright, s_r.dim_contrast, 4'h0, s_r.dim_rsv};
        OFS_SCROLL: s_nxt.rdata = {ivl_frames(s_r.scr_act.ivl), 2'b00, s_r.scr_act.voff,
          1'b0, s_r.scr_act.stop, 1'b0, s_r.scr_act.start, 1'b0, s_r.scr_act.shift,
          2'b00, s_r.scr_act.dir};
        OFS_VAREA: s_nxt.rdata = {17'h0_0000, s_r.scr_rows, 2'b00, s_r.fix_rows};
        OFS_BANKCOL: s_nxt.rdata = s_r.bank_col;
        OFS_DATACNT: s_nxt.rdata = {16'h0000, s_r.data_cnt};
        default: begin
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    s_nxt.arready = ~s_nxt.rvalid;
    // Memory data bytes are only counted
    if (data_go) begin
      s_nxt.data_cnt = s_r.data_cnt + 16'h0001;
    end
    // Command bytes
    if (cmd_go) begin
      s_nxt.opcode = b;
      s_nxt.remain = param_count(b);
      s_nxt.pidx = 3'h0;
      if (b[7:3] == OP_PAGE[7:3]) begin
        s_nxt.page_start = b[2:0];
      end
      case (b)
        OP_SEG, OP_SEG | 8'h01: s_nxt.seg_remap = b[0];
        OP_ENTIRE, OP_ENTIRE | 8'h01: s_nxt.entire_on = b[0];
        OP_INV, OP_INV | 8'h01: s_nxt.inverse = b[0];
        OP_DOFF: s_nxt.disp = ODCD_OFF;
        OP_DON: s_nxt.disp = ODCD_ON;
        OP_DON_DIM: s_nxt.disp = ODCD_DIM;
        OP_SCAN, OP_SCAN | 8'h08: s_nxt.scan_rev = b[3];
        OP_RMW_IN: s_nxt.rmw = 1'b1;
        OP_RMW_OUT: s_nxt.rmw = 1'b0;
        OP_SCR_R, OP_SCR_L: s_nxt.scr_set.dir = b[1:0];
        OP_SCR_OFF: s_nxt.scr_on = 1'b0;
        OP_SCR_ON: begin
          s_nxt.scr_on = 1'b1;
          s_nxt.scr_act = s_r.scr_set;
        end
        default: begin
        end
      endcase
    end
    // Parameter bytes
    if (prm_go) begin
      s_nxt.remain = s_r.remain - 3'h1;
      s_nxt.pidx = s_r.pidx + 3'h1;
      case (s_r.opcode)
        OP_BANK_HI: s_nxt.bank_col[{s_r.pidx[1:0], 3'h0} +: 8] = b;
        OP_MUX: s_nxt.multiplex_ratio = b[5:0];
        OP_DIM: begin
          case (s_r.pidx)
            3'h0: s_nxt.dim_rsv = b[3:0];
            3'h1: s_nxt.dim_contrast = b;
            default: s_nxt.dim_bright = b;
          endcase
        end
        OP_MCFG: s_nxt.supply_int = b[0];
        OP_OFFSET: s_nxt.disp_offset = b[5:0];
        OP_CLK: begin
          s_nxt.clk_div = b[3:0];
          s_nxt.osc_set = b[7:4];
        end
        OP_AREA: begin
          s_nxt.area_col = b[5:4];
          s_nxt.low_pwr = b[2] & b[0];
        end
        OP_PRE: begin
          s_nxt.pre1 = b[3:0];
          s_nxt.pre2 = b[7:4];
        end
        OP_PINS: begin
          s_nxt.pin_alt = b[4];
          s_nxt.lr_remap = b[5];
        end
        OP_SCR_R, OP_SCR_L: begin
          case (s_r.pidx)
            3'h0: s_nxt.scr_set.shift = b[2:0];
            3'h1: s_nxt.scr_set.start = b[2:0];
            3'h2: s_nxt.scr_set.ivl = b[2:0];
            3'h3: s_nxt.scr_set.stop = b[2:0];
            default: s_nxt.scr_set.voff = b[5:0];
          endcase
        end
        OP_VAREA: begin
          if (s_r.pidx == 3'h0) begin
            s_nxt.fix_rows = b[5:0];
          end else begin
            s_nxt.scr_rows = b[6:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= ODCD_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  AST_DISP_ON: assert property (cmd_go && b == OP_DON |=> s_r.disp == ODCD_ON)
    else $error("display on command not applied");
  AST_SEG_REMAP: assert property (cmd_go && b[7:1] == OP_SEG[7:1]
    |=> s_r.seg_remap == $past(b[0]))
    else $error("segment remap not taken from bit 0");
  AST_MUX: assert property (prm_go && s_r.opcode == OP_MUX
    |=> s_r.multiplex_ratio == $past(b[5:0]) && s_r.remain == 3'h0)
    else $error("multiplex parameter not stored");
  AST_PAGE: assert property (cmd_go && b[7:3] == OP_PAGE[7:3]
    |=> s_r.page_start == $past(b[2:0]))
    else $error("page start not loaded");
  AST_SCR_COUNT: assert property (cmd_go && b == OP_SCR_R
    |=> s_r.remain == 3'h5 && s_r.opcode == OP_SCR_R)
    else $error("scroll setup parameter count wrong");
  AST_SCR_ACT: assert property (cmd_go && b == OP_SCR_ON
    |=> s_r.scr_on && s_r.scr_act == $past(s_r.scr_set))
    else $error("scroll activation did not use latest setup");
  AST_DATA: assert property (data_go
    |=> s_r.data_cnt == $past(s_r.data_cnt) + 16'h0001 && $stable(s_r.remain))
    else $error("data byte treated as command");
  AST_CLK: assert property (prm_go && s_r.opcode == OP_CLK
    |=> s_r.clk_div == $past(b[3:0]) && s_r.osc_set == $past(b[7:4]))
    else $error("clock parameter nibbles misrouted");
  AST_BANK: assert property (prm_go && s_r.opcode == OP_BANK_HI && s_r.pidx == 3'h0
    |=> s_r.bank_col[7:0] == $past(b))
    else $error("first bank colour byte not in low bits");
  AST_RMW: assert property (cmd_go && b == OP_RMW_IN |=> s_r.rmw)
    else $error("read modify write entry failed");
  AST_STATUS: assert property (do_rd && s_axi_araddr[7:0] == OFS_STATUS
    |=> s_axi_rvalid && s_axi_rdata[STATUS_OFF_BIT] == ($past(s_r.disp) == ODCD_OFF))
    else $error("status off bit wrong");
  AST_BRESP: assert property (do_wr |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing");
  AST_DISP_OFF: assert property (cmd_go && b == OP_DOFF |=> s_r.disp == ODCD_OFF)
    else $error("display off not applied");
  AST_DISP_DIM: assert property (cmd_go && b == OP_DON_DIM |=> s_r.disp == ODCD_DIM)
    else $error("dim display on not applied");
  AST_ENTIRE: assert property (cmd_go && b[7:1] == OP_ENTIRE[7:1]
    |=> s_r.entire_on == $past(b[0]))
    else $error("entire on bit wrong");
  AST_INV: assert property (cmd_go && b[7:1] == OP_INV[7:1]
    |=> s_r.inverse == $past(b[0]))
    else $error("inverse bit wrong");
  AST_DIM: assert property (prm_go && s_r.opcode == OP_DIM && s_r.pidx == 3'h1
    |=> s_r.dim_contrast == $past(b))
    else $error("dim contrast misrouted");
  AST_DIM_BRIGHT: assert property (prm_go && s_r.opcode == OP_DIM && s_r.pidx == 3'h2
    |=> s_r.dim_bright == $past(b))
    else $error("dim brightness misrouted");
  AST_MCFG: assert property (prm_go && s_r.opcode == OP_MCFG
    |=> s_r.supply_int == $past(b[0]))
    else $error("supply select wrong");
  AST_SCAN: assert property (cmd_go && (b == OP_SCAN || b == (OP_SCAN | 8'h08))
    |=> s_r.scan_rev == $past(b[3]))
    else $error("scan direction wrong");
  AST_OFFSET: assert property (prm_go && s_r.opcode == OP_OFFSET
    |=> s_r.disp_offset == $past(b[5:0]))
    else $error("display offset not stored");
  AST_AREA: assert property (prm_go && s_r.opcode == OP_AREA
    |=> s_r.area_col == $past(b[5:4]) && s_r.low_pwr == ($past(b[2]) && $past(b[0])))
    else $error("area colour or low power wrong");
  AST_PRE: assert property (prm_go && s_r.opcode == OP_PRE
    |=> s_r.pre1 == $past(b[3:0]) && s_r.pre2 == $past(b[7:4]))
    else $error("pre-charge nibbles misrouted");
  AST_PINS: assert property (prm_go && s_r.opcode == OP_PINS
    |=> s_r.pin_alt == $past(b[4]) && s_r.lr_remap == $past(b[5]))
    else $error("row pin setting wrong");
  AST_RMW_OUT: assert property (cmd_go && b == OP_RMW_OUT |=> !s_r.rmw)
    else $error("read modify write exit failed");
  AST_SCR_SET: assert property (prm_go && s_r.opcode == OP_SCR_L && s_r.pidx == 3'h0
    |=> s_r.scr_set.shift == $past(b[2:0]) && $stable(s_r.scr_act))
    else $error("scroll shift not staged");
  AST_SCR_IVL: assert property (prm_go && s_r.opcode == OP_SCR_R && s_r.pidx == 3'h2
    |=> s_r.scr_set.ivl == $past(b[2:0]))
    else $error("scroll interval not staged");
  AST_VAREA: assert property (prm_go && s_r.opcode == OP_VAREA && s_r.pidx == 3'h1
    |=> s_r.scr_rows == $past(b[6:0]))
    else $error("scroll rows not stored");
  AST_BANK_LAST: assert property (prm_go && s_r.opcode == OP_BANK_HI && s_r.pidx == 3'h3
    |=> s_r.bank_col[31:24] == $past(b))
    else $error("last bank colour byte misplaced");
  AST_BCLR: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channels not reopened");
  AST_RCLR: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not reopened");

  COV_DON: cover property (cmd_go && b == OP_DON);
  COV_SCROLL: cover property (cmd_go && b == OP_SCR_R ##[1:40] cmd_go && b == OP_SCR_ON);
  COV_DIM: cover property (prm_go && s_r.opcode == OP_DIM && s_r.remain == 3'h1);
  COV_STATUS: cover property (do_rd && s_axi_araddr[7:0] == OFS_STATUS);

endmodule

// ===== sim/odcd_host.sv
// Host model issuing AXI4-Lite register writes and reads
module odcd_host
  import odcd_pkg::*;
(
  input wire logic mclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule

// ===== sim/odcd_decoder_tb_top.sv
// Testbench for the OLED command decoder
module odcd_decoder_tb_top
  import odcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] ra [9] = '{OFS_STATUS, OFS_MODE, OFS_GEOM, OFS_TIMING, OFS_DIM, OFS_SCROLL,
                         OFS_VAREA, OFS_BANKCOL, OFS_DATACNT};
  logic [31:0] rx [9] = '{32'h40, 32'h400, 32'h40, 32'h00227001, 32'h0, 32'h06000000,
                          32'h4000, 32'h0, 32'h0};
  logic [7:0] sc [13] = '{8'hA1, 8'hA5, 8'hA7, 8'hAF, 8'hC8, 8'hE0, 8'hAC, 8'hEE, 8'hA0,
                          8'hA4, 8'hA6, 8'hC0, 8'hAE};
  logic [15:0] sm [13] = '{16'h404, 16'h40C, 16'h41C, 16'h41D, 16'h45D, 16'h245D, 16'h245E,
                           16'h45E, 16'h45A, 16'h452, 16'h442, 16'h402, 16'h400};
  logic [7:0] frm [8] = '{8'h06, 8'h20, 8'h40, 8'h80, 8'h03, 8'h04, 8'h02, 8'h00};

  always #20 mclk = ~mclk;

  odcd_decoder odcd_decoder_i (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  odcd_host odcd_host_i (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cmd(input logic [7:0] b);
    odcd_host_i.wr(OFS_CMD, {24'h0, b}, 4'hF, resp);
  endtask

  task automatic dat(input logic [7:0] b);
    odcd_host_i.wr(OFS_CMD, {23'h0, 1'b1, b}, 4'hF, resp);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    odcd_host_i.rd(a, rv, resp);
    chk(nm, rv, exp);
    chk("rresp", {30'h0, resp}, {30'h0, RESP_OKAY});
  endtask

  task automatic scr(input logic [7:0] op, input logic [2:0] sh, input logic [2:0] st,
                     input logic [2:0] iv, input logic [2:0] en, input logic [5:0] vo);
    cmd(op);
    cmd({5'h0, sh});
    cmd({5'h0, st});
    cmd({5'h0, iv});
    cmd({5'h0, en});
    cmd({2'h0, vo});
  endtask

  function automatic logic [31:0] scw(input logic [1:0] dir, input logic [2:0] sh,
      input logic [2:0] st, input logic [2:0] iv, input logic [2:0] en, input logic [5:0] vo);
    return {frm[iv], 2'h0, vo, 1'b0, en, 1'b0, st, 1'b0, sh, 2'h0, dir};
  endfunction

  task automatic test_done();
    $display("TB: checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    failures++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rdchk("reset", ra[i], rx[i]);
    end
    $display("TB: reset values done");
    for (int i = 0; i < 13; i++) begin
      cmd(sc[i]);
      rdchk("mode", OFS_MODE, {16'h0, sm[i]});
      rdchk("status", OFS_STATUS, (sm[i][1:0] == 2'b00) ? 32'h40 : 32'h0);
    end
    $display("TB: single byte commands done");
    cmd(OP_MUX);
    dat(8'h55);
    cmd(8'h1F);
    rdchk("datacnt", OFS_DATACNT, 32'h1);
    cmd(OP_OFFSET);
    cmd(8'h3F);
    cmd(8'hB5);
    rdchk("geom", OFS_GEOM, 32'h003F0520);
    cmd(OP_CLK);
    cmd(8'hF3);
    cmd(OP_PRE);
    cmd(8'hF1);
    rdchk("timing", OFS_TIMING, 32'h00F1F304);
    cmd(OP_MCFG);
    cmd(8'h8F);
    cmd(OP_DON);
    cmd(OP_AREA);
    cmd(8'h35);
    cmd(OP_PINS);
    cmd(8'h22);
    rdchk("mode", OFS_MODE, 32'hBA1);
    cmd(OP_DIM);
    cmd(8'h00);
    cmd(8'h12);
    cmd(8'h34);
    rdchk("dim", OFS_DIM, 32'h00341200);
    cmd(OP_VAREA);
    cmd(8'h05);
    cmd(8'h1B);
    rdchk("varea", OFS_VAREA, 32'h1B05);
    cmd(OP_BANK_HI);
    cmd(8'h1B);
    cmd(8'hE4);
    cmd(8'h27);
    cmd(8'h8D);
    rdchk("bank", OFS_BANKCOL, 32'h8D27E41B);
    $display("TB: parameter commands done");
    scr(OP_SCR_L, 3'h1, 3'h2, 3'h3, 3'h4, 6'h05);
    rdchk("scroll", OFS_SCROLL, 32'h06000000);
    for (int c = 0; c < 7; c++) begin
      scr(OP_SCR_R, 3'h4, 3'h1, 3'(c), 3'h6, 6'h11);
      cmd(OP_SCR_ON);
      rdchk("scroll", OFS_SCROLL, scw(2'b01, 3'h4, 3'h1, 3'(c), 3'h6, 6'h11));
    end
    scr(OP_SCR_R, 3'h2, 3'h1, 3'h1, 3'h2, 6'h01);
    scr(OP_SCR_L, 3'h3, 3'h0, 3'h4, 3'h7, 6'h05);
    cmd(OP_SCR_ON);
    rdchk("scroll", OFS_SCROLL, scw(2'b10, 3'h3, 3'h0, 3'h4, 3'h7, 6'h05));
    rdchk("mode", OFS_MODE, 32'h1BA1);
    cmd(OP_SCR_OFF);
    dat(8'hA5);
    dat(8'h5A);
    rdchk("mode", OFS_MODE, 32'hBA1);
    rdchk("datacnt", OFS_DATACNT, 32'h3);
    $display("TB: scroll done");
    odcd_host_i.wr(OFS_STATUS, 32'hAE, 4'hF, resp);
    chk("bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    odcd_host_i.wr(OFS_CMD, 32'hAE, 4'hE, resp);
    chk("bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
    rdchk("status", OFS_STATUS, 32'h0);
    odcd_host_i.rd(8'h3C, rv, resp);
    chk("rdata", rv, 32'h0);
    chk("rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    $display("TB: refusals done");
    test_done();
  end
endmodule
